/* File: logic/fws_pkg.sv */
// Constants for the flash status polling controller.
// Assumes a 200 MHz system clock and a flash with 16-bit asynchronous data.
package fws_pkg;
  // ----------------------------------------------------------------
  // Status bit positions on the data bus
  // ----------------------------------------------------------------
  localparam int unsigned POLL_BIT   = 7;
  localparam int unsigned TOGGLE1    = 6;
  localparam int unsigned TLIMIT_BIT = 5;
  localparam int unsigned EWIN_BIT   = 3;
  localparam int unsigned TOGGLE2    = 2;

  // ----------------------------------------------------------------
  // Bus widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_W     = 23;
  localparam int unsigned CLK_PS     = 5000;
  localparam int unsigned T_ACC_PS   = 70000;
  localparam int unsigned ACC_CYC    = (T_ACC_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned GAP_CYC    = 2;
  localparam int unsigned CNT_W      = 6;

  // ----------------------------------------------------------------
  // Command words
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET  = 16'h00f0;

  // ----------------------------------------------------------------
  // Result codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_OK      = 2'h0;
  localparam logic [1:0] RES_FAIL    = 2'h1;
  localparam logic [1:0] RES_WIN_SET = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_READ  = 6'b000010,
    ST_EVAL  = 6'b000100,
    ST_RESET = 6'b001000,
    ST_DONE  = 6'b010000,
    ST_WIN   = 6'b100000
  } fws_state_t;
endpackage

/* File: logic/fws_bus_cycle.sv */
// One asynchronous flash bus cycle: read or write, framed by chip select.
// Assumes the flash samples on the strobe's rising edge and data settles in ACC_CYC.
`timescale 1ns/100ps
module fws_bus_cycle #(
  parameter int unsigned HOLD = fws_pkg::ACC_CYC
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Request
  input  wire logic                        go,
  input  wire logic                        wr,
  input  wire logic [fws_pkg::ADDR_W-1:0]  addr,
  input  wire logic [fws_pkg::DATA_W-1:0]  wdata,
  output      logic                        done,
  output      logic [fws_pkg::DATA_W-1:0]  rdata,
  // Flash pins
  output      logic [fws_pkg::ADDR_W-1:0]  fl_addr,
  output      logic                        chip_select_one_n,
  output      logic                        fl_oe_n,
  output      logic                        fl_we_n,
  output      logic [fws_pkg::DATA_W-1:0]  fl_dq_o,
  output      logic                        fl_dq_oe,
  input  wire logic [fws_pkg::DATA_W-1:0]  fl_dq_i
);
  logic [fws_pkg::CNT_W-1:0] cnt_r;
  logic                      busy_r;
  logic                      wr_r;
  wire                       last = (cnt_r == fws_pkg::CNT_W'(HOLD - 1));

  // The strobe is released after one cycle, HOLD-1 cycles before chip select rises.
  assign done     = busy_r && last;
  assign fl_dq_oe = busy_r && wr_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r  <= '0;
      wr_r   <= 1'b0;
    end else if (go && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r  <= '0;
      wr_r   <= wr;
    end else if (busy_r) begin
      busy_r <= !last;
      cnt_r  <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fl_addr           <= '0;
      fl_dq_o           <= '0;
      chip_select_one_n <= 1'b1;
      fl_oe_n           <= 1'b1;
      fl_we_n           <= 1'b1;
      rdata             <= '0;
    end else if (go && !busy_r) begin
      fl_addr           <= addr;
      fl_dq_o           <= wdata;
      chip_select_one_n <= 1'b0;
      fl_oe_n           <= wr;
      fl_we_n           <= !wr;
    end else if (busy_r) begin
      fl_oe_n           <= 1'b1;
      fl_we_n           <= 1'b1;
      chip_select_one_n <= last;
      if (last && !wr_r) begin
        rdata <= fl_dq_i;
      end
    end
  end
endmodule

/* File: logic/fws_status_poller.sv */
// Host-side poller for the flash embedded-algorithm status bits.
// Assumes the user has already written the program or erase command; this block
// reads status, judges completion and failure, and issues the reset command.
//
// Overview of operation
// - Host writes reset command after failure
// - Confirm acceptance before reading window flag; win_check judges the flag from one read, no toggle check
// - Check window flag around added sector commands
// - Host presents a valid status address
`timescale 1ns/100ps
module fws_status_poller (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // User orders
  input  wire logic                        start,
  input  wire logic                        win_check,
  input  wire logic [fws_pkg::ADDR_W-1:0]  status_addr,
  output      logic                        busy,
  output      logic                        done,
  output      logic [1:0]                  result,
  output      logic                        window_open,
  // Flash pins
  output      logic [fws_pkg::ADDR_W-1:0]  fl_addr,
  output      logic                        chip_select_one_n,
  output      logic                        fl_oe_n,
  output      logic                        fl_we_n,
  output      logic [fws_pkg::DATA_W-1:0]  fl_dq_o,
  output      logic                        fl_dq_oe,
  input  wire logic [fws_pkg::DATA_W-1:0]  fl_dq_i,
  input  wire logic                        ready_busy_output
);
  fws_pkg::fws_state_t state_r, state_nxt;
  logic [fws_pkg::ADDR_W-1:0] addr_r;
  logic [fws_pkg::DATA_W-1:0] prev_r;
  logic                       have_prev_r;
  logic                       fail_seen_r;
  logic                       win_mode_r;
  logic [1:0]                 result_r;
  logic                       window_r;
  logic [2:0]                 rb_sync_r;
  logic                       rb_r;
  logic                       cyc_done;
  logic [fws_pkg::DATA_W-1:0] cyc_data;

  // ----------------------------------------------------------------
  // Pin synchroniser for the ready/busy line
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rb_sync_r <= 3'h7;
      rb_r      <= 1'b1;
    end else begin
      rb_sync_r <= {rb_sync_r[1:0], ready_busy_output};
      if (rb_sync_r[1] == rb_sync_r[2]) begin
        rb_r <= rb_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode of one status word against the previous one
  // ----------------------------------------------------------------
  wire toggling  = have_prev_r && (cyc_data[fws_pkg::TOGGLE1] != prev_r[fws_pkg::TOGGLE1]);
  wire tlimit    = cyc_data[fws_pkg::TLIMIT_BIT];
  wire win_flag  = cyc_data[fws_pkg::EWIN_BIT];
  wire is_start  = (state_r == fws_pkg::ST_IDLE) && (start || win_check);
  wire is_read   = (state_r == fws_pkg::ST_READ);
  wire is_reset  = (state_r == fws_pkg::ST_RESET);
  wire go_cyc    = is_read || is_reset;
  // A second failing read is needed: the toggle may stop just as the flag rises.
  wire judge_fail = toggling && tlimit && fail_seen_r;

  fws_bus_cycle u_cycle (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .go                (go_cyc),
    .wr                (is_reset),
    .addr              (addr_r),
    .wdata             (fws_pkg::CMD_RESET),
    .done              (cyc_done),
    .rdata             (cyc_data),
    .fl_addr           (fl_addr),
    .chip_select_one_n (chip_select_one_n),
    .fl_oe_n           (fl_oe_n),
    .fl_we_n           (fl_we_n),
    .fl_dq_o           (fl_dq_o),
    .fl_dq_oe          (fl_dq_oe),
    .fl_dq_i           (fl_dq_i)
  );

  // rdata is taken on the edge ending the cycle; evaluation follows one cycle later.
  logic eval_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      eval_r <= 1'b0;
    end else begin
      eval_r <= cyc_done && is_read;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fws_pkg::ST_IDLE: begin
        if (start || win_check) begin
          state_nxt = fws_pkg::ST_READ;
        end
      end
      fws_pkg::ST_READ: begin
        // One framed read per pass, so toggle state advances per cycle not per clock.
        if (cyc_done) begin
          state_nxt = fws_pkg::ST_EVAL;
        end
      end
      fws_pkg::ST_EVAL: begin
        if (!eval_r) begin
          state_nxt = fws_pkg::ST_EVAL;
        end else if (win_mode_r) begin
          state_nxt = fws_pkg::ST_WIN;
        end else if (!have_prev_r) begin
          state_nxt = fws_pkg::ST_READ;
        end else if (!toggling) begin
          state_nxt = fws_pkg::ST_DONE;
        end else if (judge_fail) begin
          state_nxt = fws_pkg::ST_RESET;
        end else begin
          state_nxt = fws_pkg::ST_READ;
        end
      end
      fws_pkg::ST_WIN: begin
        state_nxt = fws_pkg::ST_DONE;
      end
      fws_pkg::ST_RESET: begin
        if (cyc_done) begin
          state_nxt = fws_pkg::ST_DONE;
        end
      end
      fws_pkg::ST_DONE: begin
        state_nxt = fws_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = fws_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= fws_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The user supplies an address inside the busy bank and erased sector.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r      <= '0;
      win_mode_r  <= 1'b0;
      have_prev_r <= 1'b0;
      prev_r      <= '0;
      fail_seen_r <= 1'b0;
    end else if (is_start) begin
      addr_r      <= status_addr;
      win_mode_r  <= win_check && !start;
      have_prev_r <= 1'b0;
      fail_seen_r <= 1'b0;
    end else if (eval_r) begin
      prev_r      <= cyc_data;
      have_prev_r <= 1'b1;
      fail_seen_r <= toggling && tlimit;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= fws_pkg::RES_OK;
      window_r <= 1'b0;
    end else if (state_r == fws_pkg::ST_WIN) begin
      // Window flag high means erase running and added sectors are refused.
      window_r <= !prev_r[fws_pkg::EWIN_BIT];
      result_r <= prev_r[fws_pkg::EWIN_BIT] ? fws_pkg::RES_WIN_SET : fws_pkg::RES_OK;
    end else if (eval_r && !win_mode_r && have_prev_r) begin
      result_r <= judge_fail ? fws_pkg::RES_FAIL : fws_pkg::RES_OK;
    end
  end

  assign busy        = (state_r != fws_pkg::ST_IDLE) || !rb_r;
  assign done        = (state_r == fws_pkg::ST_DONE);
  assign result      = result_r;
  assign window_open = window_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fail_resets;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_r == fws_pkg::ST_EVAL && eval_r && judge_fail) |=> is_reset;
  endproperty
  a_fail_resets: assert property (p_fail_resets) else $error("failure not followed by reset");

  property p_reset_writes;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(is_reset) |-> ##1 (!fl_we_n && fl_dq_oe && fl_dq_o == fws_pkg::CMD_RESET);
  endproperty
  a_reset_writes: assert property (p_reset_writes) else $error("reset command not driven");

  property p_read_framed;
    @(posedge clk_sys) disable iff (sys_rst)
      !fl_oe_n |-> !chip_select_one_n && !fl_dq_oe;
  endproperty
  a_read_framed: assert property (p_read_framed) else $error("read strobe outside frame");

  property p_addr_held;
    @(posedge clk_sys) disable iff (sys_rst)
      (!chip_select_one_n && state_r != fws_pkg::ST_IDLE) |-> fl_addr == addr_r;
  endproperty
  a_addr_held: assert property (p_addr_held) else $error("status address not held");

  property p_done_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
      done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_win_result;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_r == fws_pkg::ST_WIN && prev_r[fws_pkg::EWIN_BIT]) |=> result == fws_pkg::RES_WIN_SET && !window_open;
  endproperty
  a_win_result: assert property (p_win_result) else $error("window flag result wrong");

  property p_stop_done;
    @(posedge clk_sys) disable iff (sys_rst)
      (eval_r && !win_mode_r && have_prev_r && !toggling) |=> done && result == fws_pkg::RES_OK;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stopped toggle not reported done");

  property p_cycle_len;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(chip_select_one_n) |-> !chip_select_one_n [*8] ##1 !chip_select_one_n;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("bus cycle too short");
endmodule

/* File: verification/fws_flash_model.sv */
// Behavioural flash device for the status poller bench: status word, toggles, ready pin.
// Assumes the busy bank sits in the top three address bits; program target bit 7 is taken as 0.
`timescale 1ns/100ps
module fws_flash_model #(
  parameter logic [15:0] ARRAY_WORD = 16'h5a3c,
  parameter logic [2:0]  BANK       = 3'h6
) (
  // Clock for the bus hold model
  input  wire logic                       clk_sys,
  // Flash pins
  input  wire logic [fws_pkg::ADDR_W-1:0] fl_addr,
  input  wire logic                       chip_select_one_n,
  input  wire logic                       fl_we_n,
  input  wire logic [fws_pkg::DATA_W-1:0] fl_dq_o,
  output      logic [fws_pkg::DATA_W-1:0] fl_dq_i,
  output      logic                       ready_busy_output,
  // Scenario control
  input  wire logic                       arm,
  input  wire logic                       cfg_erase,
  input  wire logic                       cfg_fail,
  input  wire logic [7:0]                 cfg_len,
  input  wire logic [7:0]                 cfg_win,
  output      logic [7:0]                 n_reset
);
  logic        active_r = 1'b0;
  logic        tog1_r   = 1'b0;
  logic        tog2_r   = 1'b0;
  logic        wr_r     = 1'b0;
  logic [7:0]  reads_r  = 8'h00;
  logic [7:0]  win_r    = 8'h00;
  logic [15:0] last_r   = 16'h0000;
  initial n_reset = 8'h00;
  wire         hit  = fl_addr[22:20] == BANK;
  wire         tout = cfg_fail && reads_r >= cfg_len;
  wire         sel  = ~chip_select_one_n & fl_we_n & ~wr_r;
  wire  [15:0] stat = {8'h00, ~cfg_erase, tog1_r, tout, 1'b0, cfg_erase && win_r == 8'h00,
                       cfg_erase && tog2_r, 2'b00};
  wire  [15:0] word = (active_r && hit) ? stat : ARRAY_WORD;
  // A released bus shows the inverse of the last word, so stale data never passes.
  assign fl_dq_i = sel ? word : ~last_r;
  assign ready_busy_output = ~active_r;
  always @(posedge clk_sys) if (sel) last_r <= word;
  // Arming again restarts the whole acceptance window.
  always @(posedge arm) begin
    active_r = 1'b1;
    reads_r = 8'h00;
    win_r = cfg_win;
  end
  always @(posedge fl_we_n) if (!chip_select_one_n) begin
    wr_r = 1'b1;
    if (fl_dq_o === fws_pkg::CMD_RESET) begin
      active_r = 1'b0;
      n_reset = n_reset + 8'h01;
    end
  end
  always @(posedge chip_select_one_n) begin
    if (wr_r) wr_r = 1'b0;
    else if (active_r) begin
      reads_r = reads_r + 8'h01;
      tog1_r = ~tog1_r;
      if (hit) tog2_r = ~tog2_r;
      if (win_r != 8'h00) win_r = win_r - 8'h01;
      if (!cfg_fail && reads_r >= cfg_len) active_r = 1'b0;
    end
  end
endmodule

/* File: verification/fws_status_poller_tb_top.sv */
// Self-checking bench for the flash status poller.
// Assumes the flash model in this folder stands on the pins; 200 MHz clock.
`timescale 1ns/100ps
module fws_status_poller_tb_top;
  localparam logic [22:0] A_BUSY = 23'h600010;
  localparam logic [22:0] A_IDLE = 23'h200010;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        start = 1'b0;
  logic        win_check = 1'b0;
  logic        arm = 1'b0;
  logic        c_erase = 1'b0;
  logic        c_fail = 1'b0;
  logic [7:0]  c_len = 8'h00;
  logic [7:0]  c_win = 8'h00;
  logic [22:0] status_addr = '0;
  wire  logic  busy, done, window_open, cs_n, oe_n, we_n, dq_oe, rb;
  wire  logic [1:0]  result;
  wire  logic [22:0] fl_addr;
  wire  logic [15:0] dq_o, dq_i;
  wire  logic [7:0]  n_reset;
  int          bad_count = 0;
  int          n_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  fws_status_poller u_fws_status_poller (.clk_sys(clk_sys), .sys_rst(sys_rst), .start(start),
    .win_check(win_check), .status_addr(status_addr), .busy(busy), .done(done), .result(result),
    .window_open(window_open), .fl_addr(fl_addr), .chip_select_one_n(cs_n), .fl_oe_n(oe_n),
    .fl_we_n(we_n), .fl_dq_o(dq_o), .fl_dq_oe(dq_oe), .fl_dq_i(dq_i), .ready_busy_output(rb));
  fws_flash_model u_fws_flash_model (.clk_sys(clk_sys), .fl_addr(fl_addr), .chip_select_one_n(cs_n),
    .fl_we_n(we_n), .fl_dq_o(dq_o), .fl_dq_i(dq_i), .ready_busy_output(rb), .arm(arm),
    .cfg_erase(c_erase), .cfg_fail(c_fail), .cfg_len(c_len), .cfg_win(c_win), .n_reset(n_reset));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic setup(input logic er, input logic fl, input logic [7:0] len, input logic [7:0] win);
    @(negedge clk_sys);
    c_erase = er;
    c_fail = fl;
    c_len = len;
    c_win = win;
    arm = 1'b1;
    @(negedge clk_sys);
    arm = 1'b0;
  endtask
  // One order to the poller; waits a bounded time for its done pulse.
  task automatic order(input logic win, input logic [22:0] a);
    int i;
    @(negedge clk_sys);
    status_addr = a;
    start = ~win;
    win_check = win;
    @(negedge clk_sys);
    start = 1'b0;
    win_check = 1'b0;
    chk("busy_taken", 16'h1, {15'h0, busy});
    for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk_sys);
    chk("done", 16'h1, {15'h0, done});
    // Step past the done cycle so callers see the poller back in idle.
    @(negedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_program;
    setup(1'b0, 1'b0, 8'h05, 8'h00);
    chk("ready_pin", 16'h0, {15'h0, rb});
    order(1'b0, A_BUSY);
    chk("result", {14'h0, fws_pkg::RES_OK}, {14'h0, result});
    chk("resets", 16'h0, {8'h0, n_reset});
    chk("busy_after", 16'h0, {15'h0, busy});
    setup(1'b0, 1'b1, 8'h03, 8'h00);
    order(1'b0, A_BUSY);
    chk("result", {14'h0, fws_pkg::RES_FAIL}, {14'h0, result});
    chk("resets", 16'h1, {8'h0, n_reset});
    chk("ready_pin", 16'h1, {15'h0, rb});
    $display("test program done");
  endtask
  task automatic t_erase;
    setup(1'b1, 1'b0, 8'h0c, 8'h01);
    order(1'b1, A_BUSY);
    chk("window_open", 16'h1, {15'h0, window_open});
    setup(1'b1, 1'b0, 8'h0c, 8'h01);
    order(1'b1, A_BUSY);
    chk("window_open", 16'h1, {15'h0, window_open});
    order(1'b1, A_BUSY);
    chk("window_open", 16'h0, {15'h0, window_open});
    chk("result", {14'h0, fws_pkg::RES_WIN_SET}, {14'h0, result});
    order(1'b0, A_BUSY);
    chk("result", {14'h0, fws_pkg::RES_OK}, {14'h0, result});
    setup(1'b1, 1'b0, 8'h04, 8'h00);
    order(1'b1, A_BUSY);
    chk("result", {14'h0, fws_pkg::RES_WIN_SET}, {14'h0, result});
    order(1'b0, A_BUSY);
    $display("test erase done");
  endtask
  task automatic t_bank;
    setup(1'b1, 1'b0, 8'h06, 8'h00);
    order(1'b0, A_IDLE);
    chk("result_idle_bank", {14'h0, fws_pkg::RES_OK}, {14'h0, result});
    chk("busy_idle_bank", 16'h1, {15'h0, busy});
    order(1'b0, A_BUSY);
    chk("ready_pin", 16'h1, {15'h0, rb});
    $display("test bank done");
  endtask
  task automatic t_reset;
    setup(1'b0, 1'b0, 8'h08, 8'h00);
    @(negedge clk_sys);
    status_addr = A_BUSY;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (40) @(negedge clk_sys);
    sys_rst = 1'b1;
    @(negedge clk_sys);
    chk("cs_in_reset", 16'h1, {15'h0, cs_n});
    chk("busy_in_reset", 16'h0, {15'h0, busy});
    sys_rst = 1'b0;
    order(1'b0, A_BUSY);
    chk("result", {14'h0, fws_pkg::RES_OK}, {14'h0, result});
    $display("test reset done");
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_program();
    t_erase();
    t_bank();
    t_reset();
    final_report();
  end
endmodule
